// *** hdl/sobf_consts.svh ***
// Constants for the servo offset and bias front end
`ifndef SOBF_CONSTS_SVH
`define SOBF_CONSTS_SVH
`define SOBF_ADDR_CMD     4'h0
`define SOBF_ADDR_STATUS  4'h1
`define SOBF_ADDR_BIAS    4'h2
`define SOBF_ADDR_TRAV    4'h3
`define SOBF_ADDR_AVG_HI  2'h2
`define SOBF_OP_OFFSET    8'h38
`define SOBF_OP_BIAS_CTL  8'h3A
`define SOBF_OP_BIAS_WR   8'h34
`define SOBF_OP_DIV_ONE   8'h3E
`define SOBF_OP_DIV_HQ    8'h3F
`define SOBF_B_MEAS_VC    15
`define SOBF_B_COMP_VC_F  14
`define SOBF_B_MEAS_FE    13
`define SOBF_B_COMP_RF    12
`define SOBF_B_MEAS_RF    11
`define SOBF_B_COMP_FE_F  10
`define SOBF_B_TBAL_MEAS  5
`define SOBF_B_MEAS_TE    4
`define SOBF_B_COMP_ZC    3
`define SOBF_B_TBAL_COMP  2
`define SOBF_B_COMP_TE_T  1
`define SOBF_B_COMP_VC_T  0
`define SOBF_B_BIAS_ADD   14
`define SOBF_B_BIAS_CNT   13
`define SOBF_B_BIAS_UP    12
`define SOBF_B_UNDIV      0
`define SOBF_B_QUARTER    1
`define SOBF_B_HALF       0
`define SOBF_BIASW_KEY    4'hF
`define SOBF_BIASW_VAL    2'h1
`define SOBF_BIASW_LIM    2'h0
`define SOBF_MCK_HZ       5644800
`define SOBF_SERVO_HZ     88200
`define SOBF_RF_HZ        1400000
`define SOBF_SLED_HZ      345
`define SOBF_MCK_PER_SERVO (`SOBF_MCK_HZ / `SOBF_SERVO_HZ)
`define SOBF_MCK_PER_RF   (`SOBF_MCK_HZ / `SOBF_RF_HZ)
`define SOBF_MCK_PER_SLED (`SOBF_MCK_HZ / `SOBF_SLED_HZ)
`define SOBF_AVG_LAST     8'hFF
`define SOBF_AVG_SHIFT    8
`define SOBF_TRAV_SHIFT   4
`define SOBF_BIAS_W       9
`define SOBF_RST_CMD      24'h00_0000
`endif

// *** hdl/sobf_pkg.sv ***
// Types for the servo offset and bias front end
package sobf_pkg;
	typedef enum logic [1:0] {meas_idle, meas_align, meas_acc} sobf_meas_t;
	typedef enum logic [1:0] {div_one, div_half, div_quarter} sobf_div_t;
endpackage

// *** hdl/sobf_top.sv ***
// Servo clock, offset cancel, balance and focus bias front end
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sobf_consts.svh"

// Behaviour
// - Servo clock two thirds crystal, then divided
// - Rates hold at nominal 128Fs master clock
// - Focus and tracking sampled at 88.2 kHz
// - Sled sampled at 345 Hz
// - RF sampled at 1.4 MHz, zero measured
// - Servo outputs are 7-bit PWM
// - Average 256 samples into own register
// - Bits 15,13,11,4 start offset measurements
// - Measurement done 2.9 to 5.8 ms
// - Sense shows done when command byte 38
// - RF minus average, clamped at zero
// - Tracking minus centre or tracking average
// - Focus minus centre or focus average
// - Zero-cross path minus focus average
// - Balance bit loads low-pass, freezes after
// - Balance comp subtracts traverse from track, sled
// - Bias enable adds focus bias to focus
// - Bias value written from bits 9..1
// - Counter mode counts up or down
// - Step size 1, 2, 4 or 8
// - One step per focus sample
// - Counter stops at limit, sense on 3A
module sobf_top #(
	parameter int DW       = 8,                 // Sample width
	parameter int SLED_DIV = `SOBF_MCK_PER_SLED // Master ticks per sled sample
)(
	input  wire logic                clk_sys_i,     // Clock, crystal rate
	input  wire logic                sys_rst_i,     // Sync reset
	input  wire logic [3:0]          addr_i,        // Register address
	input  wire logic [31:0]         wdata_i,       // Write data
	input  wire logic                wr_i,          // Write strobe
	input  wire logic                rd_i,          // Read strobe
	output var  logic [31:0]         rdata_o,       // Read data
	input  wire logic                crystal_select_pin_i, // Crystal select
	input  wire logic [DW-1:0]       rf_level_input_i,     // RF level
	input  wire logic [DW-1:0]       centre_voltage_input_i, // Centre
	input  wire logic [DW-1:0]       focus_error_input_i,  // Focus error
	input  wire logic [DW-1:0]       tracking_error_input_i, // Track error
	input  wire logic [DW-1:0]       sled_error_input_i,   // Sled error
	output var  logic signed [DW+1:0] rf_in_o,      // RF input register
	output var  logic signed [DW+1:0] focus_in_o,   // Focus filter input
	output var  logic signed [DW+1:0] track_in_o,   // Tracking input
	output var  logic signed [DW+1:0] sled_in_o,    // Sled input
	output var  logic signed [DW+1:0] zero_cross_o, // Zero-cross input
	output var  logic                focus_pwm_o,   // Focus PWM
	output var  logic                track_pwm_o,   // Tracking PWM
	output var  logic                sled_pwm_o,    // Sled PWM
	output var  logic                sense_output_o // Sense
);
	localparam int W  = DW + 2;
	localparam int SW = DW + `SOBF_AVG_SHIFT;
	localparam int BW = `SOBF_BIAS_W;

	generate
		if (DW < 8 || DW > 16 || SLED_DIV < 2 || SLED_DIV > 65535)
		begin : g_bad
			$error("sobf_top: unsupported parameter values");
		end
	endgenerate

	function automatic logic op_is(input logic [23:0] w,
		input logic [7:0] op);
		return w[23:16] == op;
	endfunction

	function automatic logic signed [W-1:0] ext(input logic [DW-1:0] v);
		return $signed({2'h0, v});
	endfunction

	logic        wr_cmd;
	logic [23:0] wcmd;
	assign wr_cmd = wr_i && (addr_i == `SOBF_ADDR_CMD);
	assign wcmd   = wdata_i[23:0];

	// Master clock enable chain
	logic [1:0]            third_q;
	logic                  two_en_q;
	logic [1:0]            div_q;
	logic                  mck_en_q;
	logic                  undivided_bit_q;
	logic                  half_divide_bit_q;
	logic                  quarter_divide_bit_q;
	sobf_pkg::sobf_div_t   div_sel;

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			third_q  <= 2'h0;
			two_en_q <= 1'h0;
		end
		else
		begin
			third_q  <= (third_q == 2'h2) ? 2'h0 : third_q + 2'h1;
			two_en_q <= (third_q != 2'h2);
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			undivided_bit_q      <= 1'h0;
			half_divide_bit_q    <= 1'h0;
			quarter_divide_bit_q <= 1'h0;
		end
		else if (wr_cmd && op_is(wcmd, `SOBF_OP_DIV_ONE))
			undivided_bit_q <= wcmd[`SOBF_B_UNDIV];
		else if (wr_cmd && op_is(wcmd, `SOBF_OP_DIV_HQ))
		begin
			half_divide_bit_q    <= wcmd[`SOBF_B_HALF];
			quarter_divide_bit_q <= wcmd[`SOBF_B_QUARTER];
		end
	end

	always_comb
	begin
		if (undivided_bit_q)
			div_sel = sobf_pkg::div_one;
		else if (half_divide_bit_q)
			div_sel = sobf_pkg::div_half;
		else if (quarter_divide_bit_q || crystal_select_pin_i)
			div_sel = sobf_pkg::div_quarter;
		else
			div_sel = sobf_pkg::div_half;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			div_q    <= 2'h0;
			mck_en_q <= 1'h0;
		end
		else
		begin
			if (two_en_q)
				div_q <= div_q + 2'h1;
			mck_en_q <= two_en_q && (div_sel == sobf_pkg::div_one
				|| (div_sel == sobf_pkg::div_half && div_q[0])
				|| (div_sel == sobf_pkg::div_quarter && div_q == 2'h3));
		end
	end

	// Sample rate enables: focus/tracking, RF, sled
	localparam int DIVS [3] = '{`SOBF_MCK_PER_SERVO, `SOBF_MCK_PER_RF,
		SLED_DIV};
	logic [2:0] rate_en;
	logic       servo_en;
	logic       rf_en;
	logic       sled_en;

	for (genvar g = 0; g < 3; g++)
	begin : g_rate
		logic [15:0] cnt_q;
		logic        en_q;
		always_ff @(posedge clk_sys_i)
		begin
			if (sys_rst_i)
			begin
				cnt_q <= 16'h0000;
				en_q  <= 1'h0;
			end
			else
			begin
				en_q <= 1'h0;
				if (mck_en_q && cnt_q == 16'(DIVS[g] - 1))
				begin
					cnt_q <= 16'h0000;
					en_q  <= 1'h1;
				end
				else if (mck_en_q)
					cnt_q <= cnt_q + 16'h0001;
			end
		end
		assign rate_en[g] = en_q;
	end
	assign servo_en = rate_en[0];
	assign rf_en    = rate_en[1];
	assign sled_en  = rate_en[2];

	// Command words
	logic [23:0] cmd_q;
	logic [15:0] off_ctl_q;
	logic [15:0] bias_ctl_q;
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			cmd_q      <= `SOBF_RST_CMD;
			off_ctl_q  <= 16'h0000;
			bias_ctl_q <= 16'h0000;
		end
		else if (wr_cmd)
		begin
			cmd_q <= wcmd;
			if (op_is(wcmd, `SOBF_OP_OFFSET))
				off_ctl_q <= wcmd[15:0];
			if (op_is(wcmd, `SOBF_OP_BIAS_CTL))
				bias_ctl_q <= wcmd[15:0];
		end
	end

	logic rf_offset_comp, track_centre_comp, track_self_comp;
	logic focus_centre_comp, focus_self_comp, zero_cross_comp;
	logic balance_measure, balance_comp, bias_add_enable;
	logic bias_counter_mode, bias_count_direction;
	logic [1:0] bias_step_sel;
	assign rf_offset_comp       = off_ctl_q[`SOBF_B_COMP_RF];
	assign track_centre_comp    = off_ctl_q[`SOBF_B_COMP_VC_T];
	assign track_self_comp      = off_ctl_q[`SOBF_B_COMP_TE_T];
	assign focus_centre_comp    = off_ctl_q[`SOBF_B_COMP_VC_F];
	assign focus_self_comp      = off_ctl_q[`SOBF_B_COMP_FE_F];
	assign zero_cross_comp      = off_ctl_q[`SOBF_B_COMP_ZC];
	assign balance_measure      = off_ctl_q[`SOBF_B_TBAL_MEAS];
	assign balance_comp         = off_ctl_q[`SOBF_B_TBAL_COMP];
	assign bias_add_enable      = bias_ctl_q[`SOBF_B_BIAS_ADD];
	assign bias_counter_mode    = bias_ctl_q[`SOBF_B_BIAS_CNT];
	assign bias_count_direction = bias_ctl_q[`SOBF_B_BIAS_UP];
	assign bias_step_sel        = bias_ctl_q[11:10];

	// Offset measurement, index 0 RF, 1 centre, 2 focus, 3 tracking
	sobf_pkg::sobf_meas_t meas_q;
	logic [3:0]  meas_sel_q;
	logic [7:0]  meas_cnt_q;
	logic        meas_done_q;
	logic [3:0]  start_sel;
	logic        meas_start;
	logic        meas_last;
	logic [DW-1:0] smp [4];
	logic [DW-1:0] avg [4];

	assign start_sel = {wcmd[`SOBF_B_MEAS_TE], wcmd[`SOBF_B_MEAS_FE],
		wcmd[`SOBF_B_MEAS_VC], wcmd[`SOBF_B_MEAS_RF]};
	// New starts are ignored while a measurement runs
	assign meas_start = wr_cmd && op_is(wcmd, `SOBF_OP_OFFSET)
		&& |start_sel && meas_q == sobf_pkg::meas_idle;
	assign meas_last = meas_q == sobf_pkg::meas_acc && servo_en
		&& meas_cnt_q == `SOBF_AVG_LAST;
	assign smp[0] = rf_level_input_i;
	assign smp[1] = centre_voltage_input_i;
	assign smp[2] = focus_error_input_i;
	assign smp[3] = tracking_error_input_i;

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			meas_q     <= sobf_pkg::meas_idle;
			meas_sel_q <= 4'h0;
			meas_cnt_q <= 8'h00;
		end
		else
		begin
			case (meas_q)
				sobf_pkg::meas_idle:
					if (meas_start)
					begin
						meas_q     <= sobf_pkg::meas_align;
						meas_sel_q <= start_sel;
					end
				sobf_pkg::meas_align:
					if (servo_en)
					begin
						meas_q     <= sobf_pkg::meas_acc;
						meas_cnt_q <= 8'h00;
					end
				sobf_pkg::meas_acc:
					if (meas_last)
						meas_q <= sobf_pkg::meas_idle;
					else if (servo_en)
						meas_cnt_q <= meas_cnt_q + 8'h01;
				default:
					meas_q <= sobf_pkg::meas_idle;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			meas_done_q <= 1'h0;
		else if (meas_last)
			meas_done_q <= 1'h1;
		else if (meas_start)
			meas_done_q <= 1'h0;
	end

	for (genvar i = 0; i < 4; i++)
	begin : g_avg
		logic [SW-1:0] sum_q;
		logic [SW-1:0] sum_nx;
		logic [DW-1:0] avg_q;
		assign sum_nx = sum_q + SW'(smp[i]);
		always_ff @(posedge clk_sys_i)
		begin
			if (sys_rst_i)
			begin
				sum_q <= '0;
				avg_q <= '0;
			end
			else if (meas_q == sobf_pkg::meas_align && servo_en)
				sum_q <= '0;
			else if (meas_q == sobf_pkg::meas_acc && servo_en
				&& meas_sel_q[i])
			begin
				sum_q <= sum_nx;
				if (meas_cnt_q == `SOBF_AVG_LAST)
					avg_q <= sum_nx[SW-1 -: DW];
			end
		end
		assign avg[i] = avg_q;
	end

	// Compensated paths
	logic signed [W-1:0]  rf_diff, foc_base, trk_base, sld_base, bal;
	logic signed [W-1:0]  trav_q;
	logic signed [W:0]    trav_step;
	logic signed [BW-1:0] bias_q;
	logic signed [BW-1:0] limit_q;
	logic signed [W-1:0]  bias_ext;

	always_comb
	begin
		rf_diff  = ext(rf_level_input_i) - ext(avg[0]);
		foc_base = ext(focus_error_input_i) - (focus_centre_comp ?
			ext(avg[1]) : focus_self_comp ? ext(avg[2]) : '0);
		trk_base = ext(tracking_error_input_i) - (track_centre_comp ?
			ext(avg[1]) : track_self_comp ? ext(avg[3]) : '0);
		sld_base = ext(sled_error_input_i) - (track_centre_comp ?
			ext(avg[1]) : track_self_comp ? ext(avg[3]) : '0);
		bal      = balance_comp ? trav_q : '0;
		bias_ext = bias_add_enable ? W'(bias_q) : '0;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			focus_in_o   <= '0;
			track_in_o   <= '0;
			zero_cross_o <= '0;
		end
		else if (servo_en)
		begin
			focus_in_o   <= foc_base + bias_ext;
			track_in_o   <= trk_base - bal;
			zero_cross_o <= ext(focus_error_input_i)
				- (zero_cross_comp ? ext(avg[2]) : '0);
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			sled_in_o <= '0;
		else if (sled_en)
			sled_in_o <= sld_base - bal;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			rf_in_o <= '0;
		else if (rf_en)
			rf_in_o <= !rf_offset_comp ? ext(rf_level_input_i)
				: (rf_diff < 0) ? '0 : rf_diff;
	end

	// First-order low-pass; coarse shift trades speed for ripple
	// Signed operands so the shift keeps the sign of a falling error
	assign trav_step = ($signed({trk_base[W-1], trk_base})
		- $signed({trav_q[W-1], trav_q})) >>> `SOBF_TRAV_SHIFT;
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			trav_q <= '0;
		else if (balance_measure && servo_en)
			trav_q <= trav_q + trav_step[W-1:0];
	end

	// Focus bias register and counter
	logic signed [BW:0] gap;
	logic signed [BW:0] step;
	logic               bias_stop;
	logic               bias_wr;
	assign gap  = {limit_q[BW-1], limit_q} - {bias_q[BW-1], bias_q};
	assign step = $signed((BW+1)'(1) << bias_step_sel);
	assign bias_stop = bias_counter_mode && bias_q == limit_q;
	assign bias_wr = wr_cmd && op_is(wcmd, `SOBF_OP_BIAS_WR)
		&& wcmd[15:12] == `SOBF_BIASW_KEY;

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			bias_q  <= '0;
			limit_q <= '0;
		end
		else if (bias_wr)
		begin
			if (wcmd[11:10] == `SOBF_BIASW_VAL)
				bias_q <= wcmd[9:1];
			else if (wcmd[11:10] == `SOBF_BIASW_LIM)
				limit_q <= wcmd[9:1];
		end
		else if (servo_en && bias_counter_mode && !bias_stop)
		begin
			// Large steps land on the limit instead of passing it
			if (bias_count_direction)
				bias_q <= (gap > 0 && gap <= step) ? limit_q
					: bias_q + step[BW-1:0];
			else
				bias_q <= (gap < 0 && -gap <= step) ? limit_q
					: bias_q - step[BW-1:0];
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			sense_output_o <= 1'h0;
		else if (op_is(cmd_q, `SOBF_OP_OFFSET))
			sense_output_o <= meas_done_q;
		else if (op_is(cmd_q, `SOBF_OP_BIAS_CTL))
			sense_output_o <= bias_stop;
		else
			sense_output_o <= 1'h0;
	end

	// PWM, period 128 master ticks
	logic [6:0] pwm_cnt_q;
	logic signed [W-1:0] pwm_src [3];
	logic [2:0] pwm;
	assign pwm_src[0] = focus_in_o;
	assign pwm_src[1] = track_in_o;
	assign pwm_src[2] = sled_in_o;

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			pwm_cnt_q <= 7'h00;
		else if (mck_en_q)
			pwm_cnt_q <= pwm_cnt_q + 7'h01;
	end

	for (genvar k = 0; k < 3; k++)
	begin : g_pwm
		logic [6:0] duty;
		logic       pwm_q;
		assign duty = {~pwm_src[k][W-1], pwm_src[k][W-2 -: 6]};
		always_ff @(posedge clk_sys_i)
		begin
			if (sys_rst_i)
				pwm_q <= 1'h0;
			else
				pwm_q <= duty > pwm_cnt_q;
		end
		assign pwm[k] = pwm_q;
	end
	assign focus_pwm_o = pwm[0];
	assign track_pwm_o = pwm[1];
	assign sled_pwm_o  = pwm[2];

	// Read port; data stands one cycle only
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || !rd_i)
			rdata_o <= 32'h0000_0000;
		else if (addr_i == `SOBF_ADDR_CMD)
			rdata_o <= {8'h00, cmd_q};
		else if (addr_i == `SOBF_ADDR_STATUS)
			rdata_o <= 32'({div_sel, bias_stop, meas_done_q,
				meas_q != sobf_pkg::meas_idle});
		else if (addr_i == `SOBF_ADDR_BIAS)
			rdata_o <= {7'h00, limit_q, 7'h00, bias_q};
		else if (addr_i == `SOBF_ADDR_TRAV)
			rdata_o <= 32'($unsigned(trav_q));
		else if (addr_i[3:2] == `SOBF_ADDR_AVG_HI)
			rdata_o <= 32'(avg[addr_i[1:0]]);
		else
			rdata_o <= 32'h0000_0000;
	end

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	chk_clk_undiv: assert property (
		(undivided_bit_q && two_en_q) |=> mck_en_q)
		else $error("undivided master enable missed");
	chk_servo_gap: assert property (
		servo_en |=> !servo_en [*8])
		else $error("focus sample enable too frequent");
	chk_meas_start: assert property (
		(meas_start && wdata_i[`SOBF_B_MEAS_VC]) |=>
		meas_q == sobf_pkg::meas_align && meas_sel_q[1])
		else $error("centre measurement not started");
	chk_meas_end: assert property (
		meas_last |=> meas_q == sobf_pkg::meas_idle && meas_done_q)
		else $error("measurement did not finish at 256 samples");
	chk_sense_other: assert property (
		(!op_is(cmd_q, `SOBF_OP_OFFSET) && !op_is(cmd_q, `SOBF_OP_BIAS_CTL))
		|=> !sense_output_o)
		else $error("sense high outside its command bytes");
	chk_rf_clamp: assert property (
		(rf_en && rf_offset_comp && rf_diff < 0) |=> rf_in_o == 0)
		else $error("rf path not clamped");
	chk_trav_hold: assert property (
		!balance_measure |=> $stable(trav_q))
		else $error("traverse offset moved while frozen");
	chk_bias_stop: assert property (
		(bias_stop && !bias_wr) |=> $stable(bias_q))
		else $error("bias counter ran past limit");
	chk_bias_step: assert property (
		(servo_en && bias_counter_mode && bias_count_direction && !bias_wr
		&& gap > 8) |=> bias_q == $past(bias_q) + BW'($past(step)))
		else $error("bias up step wrong");
	cov_meas_done: cover property (meas_last ##1 sense_output_o);
	cov_bias_stop: cover property ($rose(bias_stop));
	cov_rf_clamp: cover property (rf_en && rf_offset_comp && rf_diff < 0);
endmodule
`default_nettype wire

// *** verif/sobf_host.sv ***
// Host model issuing servo commands over the register port
`timescale 1ns/1ps
`default_nettype none
module sobf_host (
	input  wire logic        clk_sys_i, // Clock
	input  wire logic [31:0] rdata_i,   // Read data
	output var  logic [3:0]  addr_o,    // Address
	output var  logic [31:0] wdata_o,   // Write data
	output var  logic        wr_o,      // Write strobe
	output var  logic        rd_o       // Read strobe
);
	initial
	begin
		addr_o = 4'h0;
		wdata_o = 32'h0000_0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// One command word per write, upper byte ignored by the device
	task automatic wr(input logic [3:0] a, input logic [23:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		wdata_o <= {8'h00, d};
		wr_o <= 1'b1;
		@(posedge clk_sys_i);
		wr_o <= 1'b0;
		// Stale data is scrambled so nothing leans on it
		wdata_o <= ~{8'h00, d};
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_sys_i);
		rd_o <= 1'b0;
		// Data stand only in the cycle after the strobe
		@(posedge clk_sys_i);
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the servo offset and bias front end
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int DW = 8;
	// Clocks per servo sample with the undivided master clock
	localparam int SP = 96;
	logic                 clk_sys_i = 1'b0;
	logic                 sys_rst_i = 1'b1;
	logic                 pin_q     = 1'b1;
	logic [3:0]           addr;
	logic [31:0]          wdata;
	logic                 wr;
	logic                 rd;
	logic [31:0]          rdata;
	logic [31:0]          r;
	logic [31:0]          tv;
	logic [DW-1:0]        in_q [5] = '{default: 8'h80};
	logic [DW-1:0]        avg [4];
	logic signed [DW+1:0] rf_o, fo_o, tr_o, sl_o, zc_o;
	logic                 fpwm, tpwm, spwm, sense;
	int                   err_count = 0;
	int                   cmp_count = 0;
	integer               seed = 32'h7c44_43dc;

	always #5 clk_sys_i = ~clk_sys_i;

	sobf_host host_u (
		.clk_sys_i (clk_sys_i),
		.rdata_i   (rdata),
		.addr_o    (addr),
		.wdata_o   (wdata),
		.wr_o      (wr),
		.rd_o      (rd)
	);

	sobf_top #(
		.DW       (DW),
		.SLED_DIV (4)
	) dut_u (
		.clk_sys_i              (clk_sys_i),
		.sys_rst_i              (sys_rst_i),
		.addr_i                 (addr),
		.wdata_i                (wdata),
		.wr_i                   (wr),
		.rd_i                   (rd),
		.rdata_o                (rdata),
		.crystal_select_pin_i   (pin_q),
		.rf_level_input_i       (in_q[0]),
		.centre_voltage_input_i (in_q[1]),
		.focus_error_input_i    (in_q[2]),
		.tracking_error_input_i (in_q[3]),
		.sled_error_input_i     (in_q[4]),
		.rf_in_o                (rf_o),
		.focus_in_o             (fo_o),
		.track_in_o             (tr_o),
		.sled_in_o              (sl_o),
		.zero_cross_o           (zc_o),
		.focus_pwm_o            (fpwm),
		.track_pwm_o            (tpwm),
		.sled_pwm_o             (spwm),
		.sense_output_o         (sense)
	);

	function automatic logic signed [DW+1:0] sub(input logic [DW-1:0] x,
		input logic [DW-1:0] a, input int t = 0);
		return $signed({2'b00, x}) - $signed({2'b00, a}) - t;
	endfunction

	function automatic logic signed [DW+1:0] clip(input logic [DW-1:0] x,
		input logic [DW-1:0] a);
		return (x < a) ? '0 : sub(x, a);
	endfunction

	// Ten PWM periods at 1.5 clocks per master tick
	function automatic logic near(input int h,
		input logic signed [DW+1:0] v);
		int d;
		d = 15 * {~v[DW+1], v[DW:DW-5]};
		return h >= d - 30 && h <= d + 30;
	endfunction

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wrap_up();
		$display("Compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Lead-in lets a stale sense level from the last command drain
	task automatic wait_sense(input int lim, output int n);
		repeat (4) @(posedge clk_sys_i);
		n = 0;
		while (sense !== 1'b1 && n < lim)
		begin
			@(posedge clk_sys_i);
			n++;
		end
	endtask

	task automatic div_case(input logic p, input logic [1:0] q,
		input logic u, input logic [1:0] e);
		@(posedge clk_sys_i);
		pin_q <= p;
		host_u.wr(4'h0, {8'h3f, 14'h0, q});
		host_u.wr(4'h0, {8'h3e, 15'h0, u});
		host_u.rd(4'h1, r);
		chk("div_sel", {30'h0, e}, {30'h0, r[4:3]});
	endtask

	task automatic measure(input logic [23:0] c, input logic [3:0] m);
		int n;
		@(posedge clk_sys_i);
		for (int k = 0; k < 5; k++)
		begin
			r = $random(seed);
			in_q[k] <= r[7:0];
			if (k < 4 && m[k])
				avg[k] = r[7:0];
		end
		host_u.wr(4'h0, c);
		wait_sense(60000, n);
		chk("meas_time", 1, n >= 250 * SP && n <= 514 * SP);
		for (int k = 0; k < 4; k++)
		begin
			host_u.rd(4'(8 + k), r);
			chk("average", {24'h0, avg[k]}, {24'h0, r[7:0]});
		end
		chk("sense_done", 1, sense);
		$display("Test measure done");
	endtask

	task automatic comp_case(input int i);
		logic [23:0]          c;
		logic                 fs, ts;
		logic signed [DW+1:0] e;
		int                   hi, ht, hs;
		r = $random(seed);
		fs = r[0];
		ts = r[1];
		c = 24'h38_1008 | (fs ? 24'h00_4000 : 24'h00_0400);
		c = c | (ts ? 24'h00_0001 : 24'h00_0002);
		host_u.wr(4'h0, c);
		// A later command of another kind must not undo the selection
		host_u.wr(4'h0, 24'h3a_0000);
		@(posedge clk_sys_i);
		for (int k = 0; k < 5; k++)
		begin
			r = $random(seed);
			in_q[k] <= (k == 0 && i < 2) ? avg[0] - 8'(1 - i) : r[7:0];
		end
		repeat (600) @(posedge clk_sys_i);
		chk("sense_3a", 0, sense);
		chk("rf_in", clip(in_q[0], avg[0]), rf_o);
		e = sub(in_q[2], avg[fs ? 1 : 2]);
		chk("focus_in", e, fo_o);
		chk("track_in", sub(in_q[3], avg[ts ? 1 : 3]), tr_o);
		chk("sled_in", sub(in_q[4], avg[ts ? 1 : 3]), sl_o);
		chk("zero_cross", sub(in_q[2], avg[2]), zc_o);
		if (i == 5)
		begin
			hi = 0;
			ht = 0;
			hs = 0;
			repeat (1920)
			begin
				@(posedge clk_sys_i);
				hi += (fpwm === 1'b1);
				ht += (tpwm === 1'b1);
				hs += (spwm === 1'b1);
			end
			chk("pwm_duty", 1, near(hi, e));
			e = sub(in_q[3], avg[ts ? 1 : 3]);
			chk("pwm_track", 1, near(ht, e));
			e = sub(in_q[4], avg[ts ? 1 : 3]);
			chk("pwm_sled", 1, near(hs, e));
		end
	endtask

	task automatic bias_case(input int i);
		int st, up, d, b, l, ns, n;
		st = i % 4;
		up = i / 4;
		r = $random(seed);
		d = 1 + r[4:0] % 24;
		b = up ? 40 : 140;
		l = up ? b + d : b - d;
		host_u.wr(4'h0, 24'h34_f000 | 24'(l << 1));
		host_u.wr(4'h0, 24'h34_f400 | 24'(b << 1));
		host_u.rd(4'h2, r);
		chk("bias_wr", b, r[8:0]);
		chk("limit_wr", l, r[24:16]);
		host_u.wr(4'h0, 24'(32'h3a_2000 | up << 12 | st << 10));
		wait_sense(4000, n);
		ns = (d + (1 << st) - 1) >> st;
		chk("bias_time", 1, n >= (ns - 1) * SP - 8 &&
			n <= (ns + 1) * SP + 8);
		repeat (2 * SP) @(posedge clk_sys_i);
		host_u.rd(4'h2, r);
		chk("bias_stop", l, r[8:0]);
		host_u.wr(4'h0, 24'h3a_0000);
	endtask

	initial
	begin
		repeat (5) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		div_case(1'b1, 2'b00, 1'b0, sobf_pkg::div_quarter);
		div_case(1'b0, 2'b00, 1'b0, sobf_pkg::div_half);
		div_case(1'b0, 2'b10, 1'b0, sobf_pkg::div_quarter);
		div_case(1'b1, 2'b01, 1'b0, sobf_pkg::div_half);
		div_case(1'b1, 2'b11, 1'b1, sobf_pkg::div_one);
		$display("Test divider done");
		measure(24'h38_a810, 4'hf);
		measure(24'h38_2000, 4'h4);
		for (int i = 0; i < 6; i++)
			comp_case(i);
		$display("Test compensation done");
		host_u.wr(4'h0, 24'h38_0022);
		repeat (3000) @(posedge clk_sys_i);
		host_u.wr(4'h0, 24'h38_0002);
		host_u.rd(4'h3, tv);
		@(posedge clk_sys_i);
		in_q[3] <= ~in_q[3];
		repeat (600) @(posedge clk_sys_i);
		host_u.rd(4'h3, r);
		chk("trav_hold", tv, r);
		host_u.wr(4'h0, 24'h38_0006);
		repeat (600) @(posedge clk_sys_i);
		chk("track_bal",
			sub(in_q[3], avg[3], $signed(tv[DW+1:0])), tr_o);
		chk("sled_bal",
			sub(in_q[4], avg[3], $signed(tv[DW+1:0])), sl_o);
		$display("Test balance done");
		for (int i = 0; i < 8; i++)
			bias_case(i);
		host_u.wr(4'h0, 24'h34_f428);
		host_u.wr(4'h0, 24'h38_0400);
		host_u.wr(4'h0, 24'h3a_4000);
		repeat (300) @(posedge clk_sys_i);
		chk("bias_add", sub(in_q[2], avg[2], -20), fo_o);
		$display("Test bias done");
		wrap_up();
	end

	// Two measurements dominate, about 70000 clocks at worst
	initial
	begin
		repeat (95000) @(posedge clk_sys_i);
		err_count++;
		$display("ERROR watchdog expected finish seen hang");
		wrap_up();
	end
endmodule
`default_nettype wire
